//--- pi_device_end.sv
// Display controller end of the peripheral-interface host port.
// Assumes the host keeps command low through a cycle and that pins are synchronous.
//
// How it works
// - PI mode only when all three straps low
// - Three-state interrupt output under control register
// - Upper address bits join decode
// - Host holds command low during cycle
// - Memory/IO select sampled at start rise
// - Write/read select sampled at start rise
// - Low ready ends each addressed cycle
// - Ready held low until command rises
// - Start strobe fall latches address, chip select
// - Reset floats outputs, initialises registers
// - Lower address bits address the access
// - Width from byte-high enable and bit 0
// - Sixteen-bit data over shared pins
// - Host selects memory window with chip select
`timescale 1ns/1ps
module pi_device_end
  import pi_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        bus_config_strap,
  input  wire logic        local_bus_type_bit0,
  input  wire logic        local_bus_type_bit1,
  input  wire logic        irq_source,
  pi_bus_if.device         pins,
  output logic             pi_mode,
  output logic             access_strobe,
  output logic             access_write,
  output logic             access_memory,
  output logic [23:0]      access_address,
  output logic [1:0]       access_width,
  output logic [15:0]      access_wdata,
  input  wire logic [15:0] access_rdata
);

  typedef enum logic [1:0] {IDLE, ADDRESSED, WAITING, READY} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        pi_mode;
    logic        start_prev;
    logic        cmd_prev;
    logic [23:0] address;
    logic        mem;
    logic        write;
    logic        bhe_n;
    logic        chip_sel_n;
    logic [3:0]  wait_cnt;
    logic [15:0] irq_ctrl;
    logic [15:0] rdata;
    logic        data_oe;
    logic        rdy_oe;
    logic        rdy_n;
    logic        irq_oe;
    logic        irq;
    logic        strobe;
    logic [15:0] wdata;
    logic [1:0]  width;
  } state_t;

  state_t s;
  state_t next_s;

  // True when the latched cycle falls in the display memory window or the I/O range.
  function automatic logic hits(input state_t st);
    if (st.mem)
      hits = !st.chip_sel_n && st.address[23:17] == MEM_WINDOW;
    else
      hits = st.chip_sel_n && st.address[15:4] == IO_WINDOW;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_s        = s;
    next_s.strobe = 1'b0;
    next_s.pi_mode = !bus_config_strap && !local_bus_type_bit0 && !local_bus_type_bit1;
    next_s.start_prev = pins.cycle_start_n;
    next_s.cmd_prev   = pins.cycle_command_n;
    next_s.irq_oe = s.pi_mode && s.irq_ctrl[IRQ_ENABLE_BIT];
    next_s.irq    = irq_source;

    if (s.pi_mode && s.start_prev && !pins.cycle_start_n)
    begin
      next_s.address[23:17] = pins.upper_address_bits;
      next_s.address[16:0]  = pins.lower_address_bits;
      next_s.chip_sel_n     = pins.display_chip_select_n;
      next_s.phase          = IDLE;
      next_s.rdy_oe         = 1'b0;
    end
    if (!pins.cycle_command_n)
      next_s.bhe_n = pins.byte_high_enable_n;

    unique case (s.phase)
      IDLE:
      begin
        next_s.data_oe = 1'b0;
        if (s.pi_mode && !s.start_prev && pins.cycle_start_n)
        begin
          next_s.mem   = pins.mem_io_select;
          next_s.write = pins.write_read_select;
          next_s.phase = ADDRESSED;
        end
      end
      ADDRESSED:
      begin
        // float ready unless addressed
        // Selects latched at the start rise are decoded here, one cycle later.
        if (!hits(s) || pins.cycle_command_n)
          next_s.phase = IDLE;
        else
        begin
          next_s.phase    = WAITING;
          next_s.wait_cnt = 4'h0;
          next_s.rdy_oe   = 1'b1;
          next_s.rdy_n    = 1'b1;
        end
      end
      WAITING:
      begin
        if (s.wait_cnt == ACCESS_LAST)
        begin
          next_s.phase  = READY;
          next_s.rdy_n  = 1'b0;
          next_s.strobe = 1'b1;
          next_s.wdata  = pins.host_data_in;
          if (!s.write)
          begin
            next_s.rdata   = (!s.mem && s.address[15:0] == IRQ_CTRL_IO) ? s.irq_ctrl
                                                                         : access_rdata;
            next_s.data_oe = 1'b1;
          end
          else if (!s.mem && s.address[15:0] == IRQ_CTRL_IO)
            next_s.irq_ctrl = pins.host_data_in;
        end
        else
          next_s.wait_cnt = s.wait_cnt + 4'h1;
      end
      READY:
      begin
        if (!s.cmd_prev && pins.cycle_command_n)
        begin
          next_s.phase   = IDLE;
          next_s.rdy_n   = 1'b1;
          next_s.rdy_oe  = 1'b0;
          next_s.data_oe = 1'b0;
        end
      end
    endcase

    if (!s.pi_mode)
    begin
      next_s.phase   = IDLE;
      next_s.rdy_oe  = 1'b0;
      next_s.data_oe = 1'b0;
    end

    next_s.width = decode_width(next_s.bhe_n, next_s.address[0]);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s <= '{phase: IDLE, start_prev: 1'b1, cmd_prev: 1'b1, bhe_n: 1'b1,
             chip_sel_n: 1'b1, rdy_n: 1'b1, irq_ctrl: IRQ_CTRL_RESET, default: '0};
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign pins.dev_data_out      = s.rdata;
  assign pins.dev_data_oe       = s.data_oe;
  assign pins.cycle_ready_out_n = s.rdy_n;
  assign pins.cycle_ready_oe    = s.rdy_oe;
  assign pins.irq_out           = s.irq;
  assign pins.irq_oe            = s.irq_oe;
  assign pi_mode                = s.pi_mode;
  assign access_strobe          = s.strobe;
  assign access_write           = s.write;
  assign access_memory          = s.mem;
  assign access_address         = s.address;
  assign access_wdata           = s.wdata;
  assign access_width           = s.width;

endmodule

//--- pi_port_pkg.sv
// Shared constants and types for the peripheral-interface host port.
// Assumes both ends run on one 250 MHz clock and see all pins synchronously.
package pi_port_pkg;

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned LOW_ADDR_W  = 17;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned CLOCK_MHZ   = 250;
  // Access latency the device spends after the decode before answering, in nanoseconds.
  localparam int unsigned ACCESS_NS   = 20;
  localparam int unsigned ACCESS_CYC  = (ACCESS_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0]  ACCESS_LAST = 4'(ACCESS_CYC - 1);
  // Base and size of the display memory window, as a block of address bits 23:17.
  localparam logic [6:0]  MEM_WINDOW  = 7'h05;
  // Display I/O range, upper bits of a 16-bit I/O address.
  localparam logic [11:0] IO_WINDOW   = 12'h03C;
  localparam logic [15:0] IRQ_CTRL_RESET = 16'h0000;
  localparam logic [15:0] IRQ_CTRL_IO    = 16'h03C2;
  localparam logic [3:0]  IRQ_ENABLE_BIT = 4'h4;

  typedef enum logic [1:0] {
    XFER_WORD,
    XFER_HIGH,
    XFER_LOW,
    XFER_NONE
  } xfer_t;

  function automatic xfer_t decode_width(input logic bhe_n, input logic a0);
    if (!bhe_n && !a0)
      decode_width = XFER_WORD;
    else if (!bhe_n && a0)
      decode_width = XFER_HIGH;
    else if (bhe_n && !a0)
      decode_width = XFER_LOW;
    else
      decode_width = XFER_NONE;
  endfunction

endpackage

//--- pi_bus_if.sv
// Pin bundle between the notebook CPU end and the display controller end.
// Assumes the testbench resolves the shared data bus and ready from the enables.
`timescale 1ns/1ps
interface pi_bus_if;
  logic [6:0]  upper_address_bits;
  logic [16:0] lower_address_bits;
  logic        cycle_command_n;
  logic        cycle_start_n;
  logic        mem_io_select;
  logic        write_read_select;
  logic        byte_high_enable_n;
  logic        display_chip_select_n;
  logic [15:0] host_data_in;
  logic [15:0] host_data_out;
  logic        host_data_oe;
  logic [15:0] dev_data_out;
  logic        dev_data_oe;
  logic        cycle_ready_out_n;
  logic        cycle_ready_oe;
  logic        cycle_ready_n;
  logic        irq_out;
  logic        irq_oe;

  modport device (
    input  upper_address_bits, lower_address_bits, cycle_command_n, cycle_start_n,
           mem_io_select, write_read_select, byte_high_enable_n,
           display_chip_select_n, host_data_in,
    output dev_data_out, dev_data_oe, cycle_ready_out_n, cycle_ready_oe, irq_out, irq_oe
  );
  modport host (
    output upper_address_bits, lower_address_bits, cycle_command_n, cycle_start_n,
           mem_io_select, write_read_select, byte_high_enable_n,
           display_chip_select_n, host_data_out, host_data_oe,
    input  host_data_in, cycle_ready_n
  );
endinterface

//--- pi_host_end.sv
// Notebook CPU end of the peripheral-interface host port.
// Assumes the device end answers with ready and that pins are synchronous.
`timescale 1ns/1ps
module pi_host_end
  import pi_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_memory,
  input  wire logic [23:0] req_address,
  input  wire logic        req_bhe_n,
  input  wire logic [15:0] req_wdata,
  output logic             req_busy,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  pi_bus_if.host           pins
);

  typedef enum logic [2:0] {IDLE, START, CMD, WAIT_RDY, RELEASE} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        start_n;
    logic        cmd_n;
    logic        mem;
    logic        write;
    logic        bhe_n;
    logic        cs_n;
    logic [23:0] address;
    logic [15:0] wdata;
    logic        data_oe;
    logic        busy;
    logic        rsp;
    logic [15:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_s     = s;
    next_s.rsp = 1'b0;
    unique case (s.phase)
      IDLE:
        if (req_valid)
        begin
          next_s.phase   = START;
          next_s.start_n = 1'b0;
          next_s.busy    = 1'b1;
          next_s.address = req_address;
          next_s.mem     = req_memory;
          next_s.write   = req_write;
          next_s.bhe_n   = req_bhe_n;
          next_s.wdata   = req_wdata;
          next_s.cs_n    = !(req_memory && req_address[23:17] == MEM_WINDOW);
        end
      START:
      begin
        next_s.phase   = CMD;
        next_s.start_n = 1'b1;
        next_s.cmd_n   = 1'b0;
        next_s.data_oe = s.write;
      end
      CMD:
        next_s.phase = WAIT_RDY;
      WAIT_RDY:
        if (!pins.cycle_ready_n)
        begin
          next_s.phase   = RELEASE;
          next_s.cmd_n   = 1'b1;
          next_s.data_oe = 1'b0;
          next_s.rdata   = pins.host_data_in;
          next_s.rsp     = 1'b1;
        end
      RELEASE:
      begin
        next_s.phase = IDLE;
        next_s.busy  = 1'b0;
      end
      default:
        next_s.phase = IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      s <= '{phase: IDLE, start_n: 1'b1, cmd_n: 1'b1, bhe_n: 1'b1, cs_n: 1'b1, default: '0};
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign pins.upper_address_bits    = s.address[23:17];
  assign pins.lower_address_bits    = s.address[16:0];
  assign pins.cycle_start_n         = s.start_n;
  assign pins.cycle_command_n       = s.cmd_n;
  assign pins.mem_io_select         = s.mem;
  assign pins.write_read_select     = s.write;
  assign pins.byte_high_enable_n    = s.bhe_n;
  assign pins.display_chip_select_n = s.cs_n;
  assign pins.host_data_out         = s.wdata;
  assign pins.host_data_oe          = s.data_oe;
  assign req_busy                   = s.busy;
  assign rsp_valid                  = s.rsp;
  assign rsp_rdata                  = s.rdata;

endmodule

//--- pi_bus_chk.sv
// Checker for the pins between the host end and the device end.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pi_bus_chk
  import pi_port_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [6:0]  upper_address_bits,
  input wire logic [16:0] lower_address_bits,
  input wire logic        cycle_command_n,
  input wire logic        cycle_start_n,
  input wire logic        mem_io_select,
  input wire logic        write_read_select,
  input wire logic        display_chip_select_n,
  input wire logic        dev_data_oe,
  input wire logic        cycle_ready_out_n,
  input wire logic        cycle_ready_oe,
  input wire logic        irq_oe
);
  logic hit;
  logic rdy;
  logic wr_q;
  // The decode is taken at the start rise, when both select inputs are settled.
  assign hit = mem_io_select ? (!display_chip_select_n && upper_address_bits == MEM_WINDOW)
             : (display_chip_select_n && lower_address_bits[15:4] == IO_WINDOW);
  assign rdy = cycle_ready_oe && !cycle_ready_out_n;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      wr_q <= 1'b0;
    else if ($rose(cycle_start_n))
      wr_q <= write_read_select;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_hit_gets_ready: assert property ($rose(cycle_start_n) && hit |-> ##[1:12] rdy)
    else $error("addressed cycle got no ready");
  a_miss_floats_ready: assert property ($rose(cycle_start_n) && !hit
    |-> !cycle_ready_oe [*8])
    else $error("ready driven for foreign cycle");
  a_ready_holds_low: assert property (rdy && !cycle_command_n |=> rdy)
    else $error("ready left before command rose");
  a_ready_then_floats: assert property (rdy && $rose(cycle_command_n)
    |-> ##[1:2] !cycle_ready_oe)
    else $error("ready not floated after command");
  a_read_drives_data: assert property (rdy && !wr_q |-> dev_data_oe)
    else $error("read data not driven");
  a_write_no_drive: assert property (wr_q && !cycle_command_n |-> !dev_data_oe)
    else $error("data driven during write");
  a_reset_floats_all: assert property ($rose(rstn)
    |-> !cycle_ready_oe && !dev_data_oe && !irq_oe)
    else $error("output driven out of reset");
  a_start_one_pulse: assert property ($fell(cycle_start_n)
    |=> cycle_start_n && !cycle_command_n)
    else $error("start not a single pulse");
endmodule

//--- pi_bus_host_interface_tb.sv
// Bench joining both ends; every access is checked, and read responses against a queue.
// Assumes a 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module pi_bus_host_interface_tb;
  import pi_port_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  straps = 3'h0;
  logic        irq_source = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_memory = 1'b0;
  logic [23:0] req_address = 24'h000000;
  logic        req_bhe_n = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] access_rdata = 16'h0000;
  logic        req_busy, rsp_valid, pi_mode, access_strobe, access_write, access_memory;
  logic [15:0] rsp_rdata, access_wdata, acc_wdata, rsp_last;
  logic [23:0] access_address, acc_addr;
  logic [1:0]  access_width, acc_width;
  logic        acc_wr, acc_mem;
  int          bad_count = 0, n_checks = 0, cycles = 0, n_acc = 0, n_rsp = 0;
  logic [31:0] lfsr = 32'h0001387A;
  logic [15:0] exp_q[$];
  pi_bus_if pins ();
  always #2 clock = ~clock;
  // Floated data reads as the pull-up level, floated ready as not ready.
  assign pins.host_data_in = pins.dev_data_oe ? pins.dev_data_out
                           : (pins.host_data_oe ? pins.host_data_out : 16'hFFFF);
  assign pins.cycle_ready_n = pins.cycle_ready_oe ? pins.cycle_ready_out_n : 1'b1;
  pi_host_end u_pi_host_end (.clock, .rstn, .req_valid, .req_write, .req_memory, .req_address,
    .req_bhe_n, .req_wdata, .req_busy, .rsp_valid, .rsp_rdata, .pins(pins));
  pi_device_end u_pi_device_end (.clock, .rstn, .bus_config_strap(straps[2]),
    .local_bus_type_bit0(straps[0]), .local_bus_type_bit1(straps[1]), .irq_source,
    .pins(pins), .pi_mode, .access_strobe, .access_write, .access_memory, .access_address,
    .access_width, .access_wdata, .access_rdata);
  pi_bus_chk u_pi_bus_chk (.clock, .rstn, .upper_address_bits(pins.upper_address_bits),
    .lower_address_bits(pins.lower_address_bits), .cycle_command_n(pins.cycle_command_n),
    .cycle_start_n(pins.cycle_start_n), .mem_io_select(pins.mem_io_select),
    .write_read_select(pins.write_read_select), .dev_data_oe(pins.dev_data_oe),
    .display_chip_select_n(pins.display_chip_select_n), .irq_oe(pins.irq_oe),
    .cycle_ready_out_n(pins.cycle_ready_out_n), .cycle_ready_oe(pins.cycle_ready_oe));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic check_value(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_value({23'h0, got}, {23'h0, exp});
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hold_reset();
    rstn = 1'b0;
    @(negedge clock);
    check_flag(pins.cycle_ready_oe, 1'b0);
    check_flag(pins.dev_data_oe, 1'b0);
    check_flag(pins.irq_oe, 1'b0);
    repeat (19) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One host request; a foreign cycle never ends, so it is cut off by a reset.
  task automatic xfer(input logic wr, input logic mem, input logic [23:0] addr,
                      input logic bhe, input logic [15:0] wd, input logic hit);
    int a0, r0, n, w;
    logic [15:0] rd;
    rd = next_rand();
    w = (!bhe && !addr[0]) ? 0 : (!bhe ? 1 : (!addr[0] ? 2 : 3));
    if (hit && !wr)
      exp_q.push_back(rd);
    while (req_busy !== 1'b0) @(negedge clock);
    a0 = n_acc;
    r0 = n_rsp;
    req_write = wr;
    req_memory = mem;
    req_address = addr;
    req_bhe_n = bhe;
    req_wdata = wd;
    access_rdata = rd;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (n_rsp == r0 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    check_value(24'(n_acc - a0), 24'(hit));
    check_value(24'(n_rsp - r0), 24'(hit));
    if (!hit)
      hold_reset();
    else
    begin
      check_value(acc_addr, addr);
      check_flag(acc_wr, wr);
      check_flag(acc_mem, mem);
      check_value(24'(acc_width), 24'(w));
      if (wr)
        check_value(24'(acc_wdata), 24'(wd));
      else
        check_value(24'(rsp_last), 24'(exp_q.pop_front()));
    end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (access_strobe === 1'b1)
    begin
      n_acc <= n_acc + 1;
      acc_wr <= access_write;
      acc_mem <= access_memory;
      acc_addr <= access_address;
      acc_width <= access_width;
      acc_wdata <= access_wdata;
    end
    if (rsp_valid === 1'b1)
    begin
      n_rsp <= n_rsp + 1;
      rsp_last <= rsp_rdata;
    end
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hold_reset();
    for (int s = 0; s < 8; s++)
    begin
      straps = 3'(s);
      repeat (2) @(negedge clock);
      check_flag(pi_mode, s == 0);
    end
    straps = 3'h0;
    repeat (2) @(negedge clock);
    xfer(1'b1, 1'b0, {8'h00, IRQ_CTRL_IO}, 1'b0, 16'h0001 << IRQ_ENABLE_BIT, 1'b1);
    check_flag(pins.irq_oe, 1'b1);
    irq_source = 1'b0;
    @(negedge clock);
    check_flag(pins.irq_out, 1'b0);
    irq_source = 1'b1;
    @(negedge clock);
    check_flag(pins.irq_out, 1'b1);
    xfer(1'b0, 1'b1, {7'h06, 17'h00000}, 1'b0, 16'h0000, 1'b0);
    check_flag(pins.irq_oe, 1'b0);
    for (int k = 0; k < 16; k++)
      xfer(k[0], 1'b1, {MEM_WINDOW, 1'b0, next_rand() & 16'hFFFE | 16'(k[1])}, k[2],
           next_rand(), 1'b1);
    for (int k = 0; k < 8; k++)
      xfer(k[0], 1'b0, {8'h00, IO_WINDOW, 4'(k) & 4'hC | 4'(k[1])}, k[2],
           next_rand(), 1'b1);
    xfer(1'b0, 1'b0, {MEM_WINDOW, 17'h00000}, 1'b0, 16'h0000, 1'b0);
    xfer(1'b0, 1'b1, {MEM_WINDOW, 17'h00010}, 1'b1, 16'h0000, 1'b1);
    tally_and_finish();
  end
endmodule
